/* File: flc_clear_host.sv */
`timescale 1ns/10ps

module flc_clear_host (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                nrst,
  // user side
  input  wire logic                start,
  input  wire logic                master_locked,
  input  wire logic                abort_seen,
  output logic                     busy,
  output logic                     done,
  output logic                     ok,
  output flc_pkg::flc_status_t     status,
  // flash pins
  output logic                     ce_n,
  output logic                     oe_n,
  output logic                     we_n,
  output logic [7:0]               dq_wdata,
  output logic                     dq_oe,
  input  wire logic [7:0]          dq_rdata,
  output logic                     hv_override,
  input  wire logic                ready_busy_pin
);

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [2:0]       rb_sync_ff;
  logic             rb_ready_ff;
  logic [7:0]       dq_s1_ff, dq_s2_ff, dq_s3_ff;
  logic [7:0]       dq_stable_ff;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      rb_sync_ff  <= 3'h0;
      rb_ready_ff <= 1'b0;
    end else begin
      rb_sync_ff  <= {rb_sync_ff[1:0], ready_busy_pin};
      if (rb_sync_ff[2] == rb_sync_ff[1])
        rb_ready_ff <= rb_sync_ff[1];
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      dq_s1_ff     <= 8'h00;
      dq_s2_ff     <= 8'h00;
      dq_s3_ff     <= 8'h00;
      dq_stable_ff <= 8'h00;
    end else begin
      dq_s1_ff <= dq_rdata;
      dq_s2_ff <= dq_s1_ff;
      dq_s3_ff <= dq_s2_ff;
      if (dq_s2_ff == dq_s3_ff)
        dq_stable_ff <= dq_s2_ff;
    end
  end

  // ****************************************
  // sequencer
  // ****************************************
  flc_pkg::flc_state_t      state_ff, nxt_state;
  logic [flc_pkg::CNT_W-1:0] cnt_ff;
  logic                     retried_ff;
  logic [7:0]               sr_ff;
  logic                     cnt_zero;

  assign cnt_zero = (cnt_ff == '0);

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      flc_pkg::ST_IDLE:    if (start) nxt_state = flc_pkg::ST_W_SETUP;
      flc_pkg::ST_W_SETUP: if (cnt_zero) nxt_state = flc_pkg::ST_GAP;
      flc_pkg::ST_GAP:     if (cnt_zero) nxt_state = flc_pkg::ST_W_CONF;
      flc_pkg::ST_W_CONF:  if (cnt_zero) nxt_state = flc_pkg::ST_WAIT;
      flc_pkg::ST_WAIT:    if (cnt_zero && rb_ready_ff) nxt_state = flc_pkg::ST_READ;
      flc_pkg::ST_READ:    if (cnt_zero) nxt_state = flc_pkg::ST_CHECK;
      flc_pkg::ST_CHECK: begin
        if (!sr_ff[flc_pkg::SR_READY_BIT])
          nxt_state = flc_pkg::ST_READ;
        else if (sr_ff[flc_pkg::SR_ERASE_ERR])
          nxt_state = flc_pkg::ST_W_CLR;
        else if (abort_seen && !retried_ff)
          nxt_state = flc_pkg::ST_W_SETUP;
        else
          nxt_state = flc_pkg::ST_DONE;
      end
      flc_pkg::ST_W_CLR:   if (cnt_zero) nxt_state = flc_pkg::ST_DONE;
      flc_pkg::ST_DONE:    nxt_state = flc_pkg::ST_IDLE;
      default:             nxt_state = flc_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) state_ff <= flc_pkg::ST_IDLE;
    else       state_ff <= nxt_state;
  end

  always_ff @(posedge clk) begin
    if (!nrst)
      cnt_ff <= '0;
    else if (nxt_state != state_ff) begin
      case (nxt_state)
        flc_pkg::ST_READ: cnt_ff <= flc_pkg::CNT_W'(flc_pkg::RD_WINDOW_CYC);
        flc_pkg::ST_WAIT: cnt_ff <= flc_pkg::CNT_W'(flc_pkg::BUSY_WAIT_CYC);
        default:          cnt_ff <= flc_pkg::CNT_W'(flc_pkg::WR_PULSE_CYC);
      endcase
    end else if (!cnt_zero)
      cnt_ff <= cnt_ff - 1'b1;
  end

  always_ff @(posedge clk) begin
    if (!nrst)
      retried_ff <= 1'b0;
    else if (state_ff == flc_pkg::ST_IDLE)
      retried_ff <= 1'b0;
    else if (state_ff == flc_pkg::ST_CHECK && nxt_state == flc_pkg::ST_W_SETUP)
      retried_ff <= 1'b1;
  end

  // status capture on the read pulse
  always_ff @(posedge clk) begin
    if (!nrst)
      sr_ff <= 8'h00;
    else if (state_ff == flc_pkg::ST_READ && cnt_zero)
      sr_ff <= dq_stable_ff;
  end

  // ****************************************
  // pin drive
  // ****************************************
  logic [7:0] dq_ff;
  logic       we_n_ff, oe_n_ff, ce_n_ff, dq_oe_ff, hv_ff;
  logic       wr_state;

  assign wr_state = (state_ff == flc_pkg::ST_W_SETUP) || (state_ff == flc_pkg::ST_W_CONF) ||
                    (state_ff == flc_pkg::ST_W_CLR);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      we_n_ff  <= 1'b1;
      oe_n_ff  <= 1'b1;
      ce_n_ff  <= 1'b1;
      dq_oe_ff <= 1'b0;
      dq_ff    <= 8'h00;
    end else begin
      we_n_ff  <= !(wr_state && !cnt_zero);
      oe_n_ff  <= !(state_ff == flc_pkg::ST_READ);
      ce_n_ff  <= !(wr_state || state_ff == flc_pkg::ST_READ);
      dq_oe_ff <= wr_state;
      case (state_ff)
        flc_pkg::ST_W_SETUP: dq_ff <= flc_pkg::CMD_CLR_SETUP;
        flc_pkg::ST_W_CONF:  dq_ff <= flc_pkg::CMD_CLR_CONFIRM;
        flc_pkg::ST_W_CLR:   dq_ff <= flc_pkg::CMD_CLR_STATUS;
        default:             dq_ff <= dq_ff;
      endcase
    end
  end

  // override level held through the whole operation when the master bit is set
  always_ff @(posedge clk) begin
    if (!nrst)
      hv_ff <= 1'b0;
    else if (state_ff == flc_pkg::ST_IDLE)
      hv_ff <= start && master_locked;
    else if (state_ff == flc_pkg::ST_DONE)
      hv_ff <= 1'b0;
  end

  assign we_n        = we_n_ff;
  assign oe_n        = oe_n_ff;
  assign ce_n        = ce_n_ff;
  assign dq_oe       = dq_oe_ff;
  assign dq_wdata    = dq_ff;
  assign hv_override = hv_ff;

  // ****************************************
  // user side results
  // ****************************************
  logic done_ff, ok_ff;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      done_ff <= 1'b0;
      ok_ff   <= 1'b0;
    end else begin
      done_ff <= (state_ff == flc_pkg::ST_DONE);
      if (state_ff == flc_pkg::ST_DONE)
        ok_ff <= !sr_ff[flc_pkg::SR_ERASE_ERR];
    end
  end

  assign busy = (state_ff != flc_pkg::ST_IDLE);
  assign done = done_ff;
  assign ok   = ok_ff;

  always_comb begin
    status.ready      = sr_ff[flc_pkg::SR_READY_BIT];
    status.esusp      = sr_ff[flc_pkg::SR_ESUSP_BIT];
    status.erase_err  = sr_ff[flc_pkg::SR_ERASE_ERR];
    status.prog_err   = sr_ff[flc_pkg::SR_PROG_ERR];
    status.supply_err = sr_ff[flc_pkg::SR_SUPPLY_ERR];
    status.wsusp      = sr_ff[flc_pkg::SR_WSUSP_BIT];
    status.protect    = sr_ff[flc_pkg::SR_PROTECT_BIT];
  end

endmodule

/* File: flc_pkg.sv */
package flc_pkg;

  // ****************************************
  // status register fields
  // ****************************************
  localparam int SR_READY_BIT    = 7;
  localparam int SR_ESUSP_BIT    = 6;
  localparam int SR_ERASE_ERR    = 5;
  localparam int SR_PROG_ERR     = 4;
  localparam int SR_SUPPLY_ERR   = 3;
  localparam int SR_WSUSP_BIT    = 2;
  localparam int SR_PROTECT_BIT  = 1;

  // ****************************************
  // command codes, neutral defaults
  // ****************************************
  localparam logic [7:0] CMD_CLR_SETUP   = 8'h60;
  localparam logic [7:0] CMD_CLR_CONFIRM = 8'hd0;
  localparam logic [7:0] CMD_CLR_STATUS  = 8'h50;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_NS        = 50;
  localparam int WR_PULSE_NS   = 100;
  localparam int WR_PULSE_CYC  = (WR_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int RD_ACCESS_NS  = 150;
  localparam int RD_ACCESS_CYC = (RD_ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int RD_WINDOW_CYC = RD_ACCESS_CYC + 4;
  localparam int BUSY_WAIT_CYC = 4;
  localparam int CNT_W         = 4;

  // ****************************************
  // types
  // ****************************************
  typedef struct packed {
    logic       ready;
    logic       erase_err;
    logic       prog_err;
    logic       supply_err;
    logic       protect;
    logic       esusp;
    logic       wsusp;
  } flc_status_t;

  typedef enum logic [3:0] {
    ST_IDLE    = 4'b0000,
    ST_W_SETUP = 4'b0001,
    ST_GAP     = 4'b0011,
    ST_W_CONF  = 4'b0010,
    ST_WAIT    = 4'b0110,
    ST_READ    = 4'b0111,
    ST_CHECK   = 4'b0101,
    ST_W_CLR   = 4'b0100,
    ST_DONE    = 4'b1100
  } flc_state_t;

endpackage

/* File: flc_clear_host_checker.sv */
`timescale 1ns/10ps
// ****************
// sequencer checks
// ****************
module flc_clear_host_checker (
  // clock and reset
  input wire logic                 clk,
  input wire logic                 nrst,
  // user side
  input wire logic                 start,
  input wire logic                 master_locked,
  input wire logic                 busy,
  input wire logic                 done,
  input wire logic                 ok,
  input wire flc_pkg::flc_status_t status,
  // flash pins
  input wire logic                 ce_n,
  input wire logic                 oe_n,
  input wire logic                 we_n,
  input wire logic [7:0]           dq_wdata,
  input wire logic                 dq_oe,
  input wire logic                 hv_override
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  a_setup_first: assert property (start && !busy |-> ##[1:4] (!we_n && dq_wdata == flc_pkg::CMD_CLR_SETUP))
    else $error("setup write missing");
  a_we_width: assert property ($fell(we_n) |-> !we_n [*2])
    else $error("write pulse short");
  a_write_drives: assert property (!we_n |-> dq_oe && !ce_n && oe_n)
    else $error("write without bus");
  a_read_floats: assert property (!oe_n |-> !dq_oe && we_n && !ce_n)
    else $error("read with bus driven");
  a_hv_master: assert property (start && !busy && master_locked |=> ##[0:1] hv_override)
    else $error("override not raised");
  a_done_ready: assert property (done |-> status.ready)
    else $error("done while not ready");
  a_ok_error: assert property (done |-> ok != status.erase_err)
    else $error("ok disagrees with status");
  a_ok_holds: assert property (!done |-> $stable(ok))
    else $error("ok moved without done");
  c_pass: cover property (done && ok);
  c_fail: cover property (done && !ok);
  c_hv: cover property (hv_override && !we_n);
endmodule

bind flc_clear_host flc_clear_host_checker u_chk (.clk(clk), .nrst(nrst), .start(start),
  .master_locked(master_locked), .busy(busy), .done(done), .ok(ok), .status(status), .ce_n(ce_n),
  .oe_n(oe_n), .we_n(we_n), .dq_wdata(dq_wdata), .dq_oe(dq_oe), .hv_override(hv_override));

/* File: flc_flash_model.sv */
`timescale 1ns/10ps
// ****************
// flash device model
// ****************
module flc_flash_model (
  // pins
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       ce_n,
  input  wire logic       oe_n,
  input  wire logic       we_n,
  input  wire logic [7:0] wdata,
  input  wire logic       hv,
  output logic [7:0]      rdata,
  output logic            rdy_pin,
  // test controls
  input  wire logic       master_bit,  // never cleared here
  input  wire logic       supply_low,
  input  wire logic [7:0] dly,
  output logic [7:0]      locks_ff,
  output logic [7:0]      clears_ff,
  output logic [7:0]      sclr_ff,
  // protection matrix
  output logic [7:0]      erase_en,
  output logic            setblk_en,
  output logic            setmst_en
);
  logic [7:0] sr_ff, res_ff, cnt_ff, d_ff, rd;
  logic       we_ff, ce_ff, setup_ff;
  assign rdy_pin = sr_ff[7];
  assign rd = sr_ff[7] ? sr_ff : {1'b0, cnt_ff[6:0] ^ 7'h55};
  assign rdata = (!ce_n && !oe_n) ? rd : ~rd;
  // write protection for erase and lock-bit setting
  assign erase_en  = ~locks_ff | {8{hv}};
  assign setblk_en = !master_bit || hv;
  assign setmst_en = hv;
  always_ff @(posedge clk) begin
    we_ff <= we_n;
    ce_ff <= ce_n;
    d_ff <= wdata;
    if (!nrst) begin
      sr_ff <= 8'h80;
      setup_ff <= 1'b0;
      cnt_ff <= 8'h00;
      locks_ff <= 8'hff;
      clears_ff <= 8'h00;
      sclr_ff <= 8'h00;
    end else if (cnt_ff != 8'h00) begin
      cnt_ff <= cnt_ff - 8'h01;
      if (cnt_ff == 8'h01) sr_ff <= res_ff;
    end else if (!ce_ff && we_n && !we_ff) begin
      setup_ff <= (d_ff == flc_pkg::CMD_CLR_SETUP);
      if (d_ff == flc_pkg::CMD_CLR_STATUS) begin
        sr_ff <= 8'h80;
        sclr_ff <= sclr_ff + 8'h01;
      end
      if (setup_ff && d_ff != flc_pkg::CMD_CLR_CONFIRM) sr_ff <= 8'hb0;
      if (setup_ff && d_ff == flc_pkg::CMD_CLR_CONFIRM) begin
        sr_ff <= 8'h00;
        cnt_ff <= dly;
        clears_ff <= clears_ff + 8'h01;
        if (supply_low) res_ff <= 8'ha8;
        else if (master_bit && !hv) res_ff <= 8'ha2;
        else begin
          res_ff <= 8'h80;
          locks_ff <= 8'h00;
        end
      end
    end
  end
endmodule

/* File: tb_top.sv */
`timescale 1ns/10ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin bad_count++; $display("unexpected %s exp %h got %h", n, e, g); end end
module tb_top;
  logic clk = 1'b0, nrst = 1'b0, start = 1'b0, master_locked = 1'b0, abort_seen = 1'b0;
  logic master_bit = 1'b0, supply_low = 1'b0;
  logic [7:0] dly = 8'h02;
  logic busy, done, ok, ce_n, oe_n, we_n, dq_oe, hv_override, rdy, setblk_en, setmst_en;
  logic [7:0] dq_wdata, dq_rdata, locks, clears, sclr, erase_en;
  flc_pkg::flc_status_t status;
  int bad_count = 0, compares = 0, cycles = 0;
  always #25 clk = ~clk;
  flc_clear_host u_flc_clear_host (.clk(clk), .nrst(nrst), .start(start), .master_locked(master_locked),
    .abort_seen(abort_seen), .busy(busy), .done(done), .ok(ok), .status(status), .ce_n(ce_n), .oe_n(oe_n),
    .we_n(we_n), .dq_wdata(dq_wdata), .dq_oe(dq_oe), .dq_rdata(dq_rdata), .hv_override(hv_override),
    .ready_busy_pin(rdy));
  flc_flash_model u_flc_flash_model (.clk(clk), .nrst(nrst), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
    .wdata(dq_oe ? dq_wdata : ~dq_wdata), .hv(hv_override), .rdata(dq_rdata), .rdy_pin(rdy),
    .master_bit(master_bit), .supply_low(supply_low), .dly(dly), .locks_ff(locks), .clears_ff(clears),
    .sclr_ff(sclr), .erase_en(erase_en), .setblk_en(setblk_en), .setmst_en(setmst_en));
  task automatic complete_run();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      complete_run();
    end
  end
  task automatic do_clear(input logic m, input logic um, input logic lo, input logic ab, input logic [7:0] d);
    int n;
    @(posedge clk);
    nrst <= 1'b0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    master_bit <= m;
    master_locked <= um;
    supply_low <= lo;
    abort_seen <= ab;
    dly <= d;
    @(posedge clk);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    #1;
    `CHK("busy", 1'b1, busy)
    n = 0;
    while (done !== 1'b1 && n < 500) begin
      @(posedge clk) #1;
      n++;
    end
    `CHK("done", 1'b1, done)
    `CHK("busy", 1'b0, busy)
  endtask
  task automatic t_plain();
    do_clear(1'b0, 1'b0, 1'b0, 1'b0, 8'h02);
    `CHK("status", 7'h40, status)
    `CHK("locks", 8'h00, locks)
    `CHK("clears", 8'h01, clears)
    `CHK("erase_en", 8'hff, erase_en)
    `CHK("setblk_en", 1'b1, setblk_en)
  endtask
  task automatic t_master_hv();
    do_clear(1'b1, 1'b1, 1'b0, 1'b0, 8'h3c);
    `CHK("ok", 1'b1, ok)
    `CHK("locks", 8'h00, locks)
    `CHK("setblk_en", 1'b0, setblk_en)
    `CHK("setmst_en", 1'b0, setmst_en)
  endtask
  task automatic t_protect();
    do_clear(1'b1, 1'b0, 1'b0, 1'b0, 8'h03);
    `CHK("status", 7'h64, status)
    `CHK("locks", 8'hff, locks)
    `CHK("sclr", 8'h01, sclr)
    `CHK("erase_en", 8'h00, erase_en)
  endtask
  task automatic t_supply();
    do_clear(1'b0, 1'b0, 1'b1, 1'b0, 8'h03);
    `CHK("status", 7'h68, status)
    `CHK("locks", 8'hff, locks)
    `CHK("ok", 1'b0, ok)
  endtask
  task automatic t_abort();
    do_clear(1'b0, 1'b0, 1'b0, 1'b1, 8'h03);
    `CHK("clears", 8'h02, clears)
    `CHK("status", 7'h40, status)
  endtask
  initial begin
    t_plain();
    t_master_hv();
    t_protect();
    t_supply();
    t_abort();
    complete_run();
  end
endmodule
